// *** src/fwr_pkg.sv ***
// package of register offsets, fields and timing for the fill-level and reset control block
package fwr_pkg;
    // register offsets are not word-aligned, so each is an index; byte address = 4 * index
    localparam logic [7:0] IDX_THRESH_HIGH  = 8'h60;
    localparam logic [7:0] IDX_THRESH_LOW   = 8'h61;
    localparam logic [7:0] IDX_PATH_RESET   = 8'h68;
    localparam logic [7:0] IDX_MOTION_CTRL  = 8'h69;
    localparam logic [7:0] IDX_USER_CTRL    = 8'h6a;
    localparam logic [7:0] IDX_FIFO_DATA    = 8'h74;
    localparam logic [7:0] IDX_IRQ_STATUS   = 8'h75;
    localparam logic [7:0] IDX_FIFO_COUNT   = 8'h76;
    localparam logic [7:0] IDX_CFG_1A       = 8'h1a;
    localparam logic [7:0] IDX_INT_CFG      = 8'h77;

    localparam logic [7:0] RST_THRESH_HIGH  = 8'h00;
    localparam logic [7:0] RST_THRESH_LOW   = 8'h00;
    localparam logic [7:0] RST_MOTION_CTRL  = 8'h00;
    localparam logic [7:0] RST_USER_CTRL    = 8'h00;
    localparam logic [7:0] RST_CFG_1A       = 8'h00;

    localparam logic [7:0] MASK_THRESH_HIGH = 8'h03;
    localparam logic [7:0] MASK_PATH_RESET  = 8'h03;
    localparam logic [7:0] MASK_MOTION_CTRL = 8'hc3;
    localparam logic [7:0] MASK_USER_CTRL   = 8'h40;
    localparam logic [7:0] MASK_INT_CFG     = 8'h01;

    localparam int BIT_TEMP_RST     = 0;
    localparam int BIT_ACCEL_RST    = 1;
    localparam int BIT_AXIS_COMBINE = 0;
    localparam int BIT_NO_LIMIT     = 1;
    localparam int BIT_COMPARE_MODE = 6;
    localparam int BIT_MOTION_EN    = 7;
    localparam int BIT_ALL_RST      = 0;
    localparam int BIT_FIFO_RST     = 2;
    localparam int BIT_FIFO_EN      = 6;
    localparam int BIT_LATCH_MODE   = 0;
    localparam int BIT_FILL_FLAG    = 0;
    localparam int BIT_CFG_1A_TOP   = 7;

    // reset pulse: one period of the 20 MHz internal clock, counted in 4 ns cycles
    localparam int CLK_SYS_PS       = 4000;
    localparam int FIFO_RST_PS      = 50000;
    localparam int FIFO_RST_CYCLES  = (FIFO_RST_PS + CLK_SYS_PS - 1) / CLK_SYS_PS;
    localparam int PATH_RST_CYCLES  = 1;

    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
endpackage

// *** src/fwr_pulse_gen.sv ***
// fixed-length pulse generator used for the path and fifo resets
`timescale 1ns/1ps
module fwr_pulse_gen #(
    parameter int LEN = 1
) (
    // clock and reset
    input  wire logic clk_sys_i,
    input  wire logic nrst_i,
    // trigger and pulse
    input  wire logic start_i,
    output logic      pulse_o
);
    initial begin
        if (LEN < 1 || LEN > 255) $error("pulse length out of range");
    end

    typedef struct packed {
        logic [7:0] cnt;
    } fwr_pg_state_t;

    fwr_pg_state_t st;
    fwr_pg_state_t next_st;

    always_comb begin
        next_st = st;
        if (start_i) begin
            next_st.cnt = 8'(LEN);
        end else if (st.cnt != 8'h00) begin
            next_st.cnt = st.cnt - 8'h01;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign pulse_o = (st.cnt != 8'h00);
endmodule

// *** src/fwr_ctrl.sv ***
// fill-level threshold interrupt, fifo control, path resets and motion settings behind ahb-lite
//
// Our own choice: the AHB-Lite register port.
`timescale 1ns/1ps
module fwr_ctrl
    import fwr_pkg::*;
#(
    parameter int CNT_W = 16
) (
    // clock and reset
    input  wire logic              clk_sys_i,
    input  wire logic              nrst_i,
    // ahb-lite slave
    input  wire logic              hsel_i,
    input  wire logic [31:0]       haddr_i,
    input  wire logic [1:0]        htrans_i,
    input  wire logic              hwrite_i,
    input  wire logic [2:0]        hsize_i,
    input  wire logic [31:0]       hwdata_i,
    input  wire logic              hready_i,
    output logic [31:0]            hrdata_o,
    output logic                   hreadyout_o,
    output logic                   hresp_o,
    // fifo side
    input  wire logic [CNT_W-1:0]  fifo_count_i,
    input  wire logic [7:0]        fifo_rdata_i,
    input  wire logic              fifo_read_busy_i,
    output logic                   fifo_pop_o,
    output logic                   fifo_enable_o,
    output logic                   fifo_reset_o,
    // signal path control
    output logic                   accel_path_reset_o,
    output logic                   temp_path_reset_o,
    output logic                   gyro_path_reset_o,
    output logic                   sensor_regs_clear_o,
    // wake-on-motion settings
    output logic                   motion_detect_enable_o,
    output logic                   motion_compare_mode_o,
    output logic                   output_limit_off_o,
    output logic                   motion_axis_combine_o,
    // interrupt pin
    output logic                   irq_o
);
    initial begin
        if (CNT_W < 10 || CNT_W > 16) $error("fifo count width unsupported");
    end

    typedef struct packed {
        logic        ph_valid;
        logic        ph_write;
        logic [7:0]  ph_idx;
        logic [31:0] rdata;
        logic [7:0]  thresh_high;
        logic [7:0]  thresh_low;
        logic [7:0]  motion_ctrl;
        logic [7:0]  user_ctrl;
        logic [7:0]  cfg_1a;
        logic        latch_mode;
        logic        fill_flag;
        logic        irq_level;
        logic        irq_pulse;
        logic        in_seq;
    } fwr_state_t;

    fwr_state_t st;
    fwr_state_t next_st;

    logic [9:0] thresh;
    logic       cond;
    logic       reading;
    logic       data_read;
    logic       wr_path;
    logic       wr_user;
    logic [7:0] wbyte;
    logic       fifo_rst_pulse;
    logic       accel_pulse;
    logic       temp_pulse;
    logic       all_pulse;

    function automatic logic [7:0] addr_idx(input logic [31:0] a);
        return a[9:2];
    endfunction

    // threshold assembled from both registers
    assign thresh  = {st.thresh_high[1:0], st.thresh_low};
    // busy is a host-side level on this clock, so it needs no synchroniser
    assign reading = fifo_read_busy_i || st.in_seq;
    // zero threshold never triggers
    assign cond    = (thresh != 10'h000) && (fifo_count_i >= CNT_W'(thresh));
    assign wbyte   = hwdata_i[7:0];
    assign data_read = st.ph_valid && !st.ph_write && (st.ph_idx == IDX_FIFO_DATA)
                       && st.user_ctrl[BIT_FIFO_EN];
    assign wr_path = st.ph_valid && st.ph_write && (st.ph_idx == IDX_PATH_RESET);
    assign wr_user = st.ph_valid && st.ph_write && (st.ph_idx == IDX_USER_CTRL);

    always_comb begin
        next_st = st;
        next_st.irq_pulse = 1'b0;
        // address phase capture
        next_st.ph_valid = hsel_i && hready_i && htrans_i[1];
        next_st.ph_write = hwrite_i;
        next_st.ph_idx   = addr_idx(haddr_i);
        // write data phase; reserved bits masked
        if (st.ph_valid && st.ph_write) begin
            case (st.ph_idx)
                IDX_THRESH_HIGH: next_st.thresh_high = wbyte & MASK_THRESH_HIGH;
                IDX_THRESH_LOW:  next_st.thresh_low  = wbyte;
                IDX_MOTION_CTRL: next_st.motion_ctrl = wbyte & MASK_MOTION_CTRL;
                IDX_USER_CTRL:   next_st.user_ctrl   = wbyte & MASK_USER_CTRL;
                IDX_CFG_1A:      next_st.cfg_1a      = wbyte;
                IDX_INT_CFG:     next_st.latch_mode  = wbyte[BIT_LATCH_MODE];
                default: ;
            endcase
        end
        // read data for the next data phase
        next_st.rdata = 32'h0000_0000;
        if (hsel_i && hready_i && htrans_i[1] && !hwrite_i) begin
            case (addr_idx(haddr_i))
                IDX_THRESH_HIGH: next_st.rdata[7:0] = st.thresh_high;
                IDX_THRESH_LOW:  next_st.rdata[7:0] = st.thresh_low;
                IDX_MOTION_CTRL: next_st.rdata[7:0] = st.motion_ctrl;
                IDX_USER_CTRL:   next_st.rdata[7:0] = st.user_ctrl;
                IDX_CFG_1A:      next_st.rdata[7:0] = st.cfg_1a;
                IDX_INT_CFG:     next_st.rdata[BIT_LATCH_MODE] = st.latch_mode;
                IDX_IRQ_STATUS:  next_st.rdata[BIT_FILL_FLAG] = st.fill_flag;   // no clear on read
                IDX_FIFO_COUNT:  next_st.rdata[CNT_W-1:0] = fifo_count_i;
                // fifo disabled blocks data access
                IDX_FIFO_DATA:   next_st.rdata[7:0] = st.user_ctrl[BIT_FIFO_EN] ? fifo_rdata_i : 8'h00;
                default: ;
            endcase
        end
        // read sequence tracking: first data read clears, later ones do not
        if (data_read && !st.in_seq) begin
            next_st.in_seq    = 1'b1;
            next_st.fill_flag = 1'b0;
            if (st.latch_mode) begin
                next_st.irq_level = 1'b0;
            end
        end
        // sequence ends when the external read window closes after a data read
        if (st.in_seq && !fifo_read_busy_i && !data_read) begin
            next_st.in_seq = 1'b0;
            if (cond) begin
                // re-arm at read end; latched pin only now
                next_st.fill_flag = 1'b1;
                if (st.latch_mode) begin
                    next_st.irq_level = 1'b1;
                end else begin
                    next_st.irq_pulse = 1'b1;
                end
            end
        end else if (!reading && cond && !st.fill_flag && !data_read) begin
            // trigger on level while idle; a data read in the same cycle blocks the set
            next_st.fill_flag = 1'b1;
            if (st.latch_mode) begin
                next_st.irq_level = 1'b1;
            end else begin
                next_st.irq_pulse = 1'b1;
            end
        end
        // fifo reset bit self-clears, never stored
        if (wr_user) begin
            next_st.user_ctrl[BIT_FIFO_RST] = 1'b0;
        end
        if (!st.latch_mode) begin
            next_st.irq_level = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st <= '0;
            st.thresh_high <= RST_THRESH_HIGH;
            st.thresh_low  <= RST_THRESH_LOW;
            st.motion_ctrl <= RST_MOTION_CTRL;
            st.user_ctrl   <= RST_USER_CTRL;
            st.cfg_1a      <= RST_CFG_1A;
        end else begin
            st <= next_st;
        end
    end

    // reset pulses: fifo reset lasts one 20 MHz period
    fwr_pulse_gen #(.LEN(FIFO_RST_CYCLES)) u_fifo_rst (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .start_i   (wr_user && wbyte[BIT_FIFO_RST]),
        .pulse_o   (fifo_rst_pulse)
    );

    // accel path only; sensor outputs untouched
    fwr_pulse_gen #(.LEN(PATH_RST_CYCLES)) u_accel_rst (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .start_i   (wr_path && wbyte[BIT_ACCEL_RST]),
        .pulse_o   (accel_pulse)
    );

    // temp path only; sensor outputs untouched
    fwr_pulse_gen #(.LEN(PATH_RST_CYCLES)) u_temp_rst (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .start_i   (wr_path && wbyte[BIT_TEMP_RST]),
        .pulse_o   (temp_pulse)
    );

    // all paths plus sensor register clear
    fwr_pulse_gen #(.LEN(PATH_RST_CYCLES)) u_all_rst (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .start_i   (wr_user && wbyte[BIT_ALL_RST]),
        .pulse_o   (all_pulse)
    );

    assign hrdata_o               = st.rdata;
    assign hreadyout_o            = 1'b1;
    assign hresp_o                = 1'b0;
    assign fifo_pop_o             = data_read;
    assign fifo_enable_o          = st.user_ctrl[BIT_FIFO_EN];
    assign fifo_reset_o           = fifo_rst_pulse;
    assign accel_path_reset_o     = accel_pulse || all_pulse;
    assign temp_path_reset_o      = temp_pulse || all_pulse;
    assign gyro_path_reset_o      = all_pulse;
    assign sensor_regs_clear_o    = all_pulse;
    assign motion_detect_enable_o = st.motion_ctrl[BIT_MOTION_EN];
    assign motion_compare_mode_o  = st.motion_ctrl[BIT_COMPARE_MODE];
    assign output_limit_off_o     = st.motion_ctrl[BIT_NO_LIMIT];
    assign motion_axis_combine_o  = st.motion_ctrl[BIT_AXIS_COMBINE];
    assign irq_o                  = st.irq_level || st.irq_pulse;

    // checks
    property p_zero_off;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (thresh == 10'h000 && $past(thresh) == 10'h000 && !st.fill_flag) |=> !st.fill_flag;
    endproperty
    a_zero_off: assert property (p_zero_off) else $error("flag set with zero threshold");

    property p_trigger;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (cond && !reading && !st.fill_flag && !data_read) |=> st.fill_flag;
    endproperty
    a_trigger: assert property (p_trigger) else $error("trigger did not set flag");

    property p_pulse;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        ($rose(st.fill_flag) && !$past(st.latch_mode)) |-> st.irq_pulse ##1 !st.irq_pulse;
    endproperty
    a_pulse: assert property (p_pulse) else $error("pulse mode pin wrong");

    property p_clear;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (data_read && !st.in_seq) |=> !st.fill_flag && st.in_seq;
    endproperty
    a_clear: assert property (p_clear) else $error("first data read did not clear");

    property p_latch_drop;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (data_read && !st.in_seq && st.latch_mode) |=> !irq_o;
    endproperty
    a_latch_drop: assert property (p_latch_drop) else $error("latched pin not dropped");

    property p_no_set_in_seq;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (st.in_seq && (fifo_read_busy_i || data_read)) |=> !$rose(st.irq_level);
    endproperty
    a_no_set_in_seq: assert property (p_no_set_in_seq) else $error("pin set during read");

    property p_rearm;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (st.in_seq && !fifo_read_busy_i && !data_read && cond) |=> st.fill_flag && !st.in_seq;
    endproperty
    a_rearm: assert property (p_rearm) else $error("no re-arm at read end");

    property p_fifo_rst_len;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        $rose(fifo_reset_o) |-> fifo_reset_o [*8] ##1 fifo_reset_o [*5] ##1 !fifo_reset_o;
    endproperty
    a_fifo_rst_len: assert property (p_fifo_rst_len) else $error("fifo reset length wrong");

    property p_fifo_block;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        !st.user_ctrl[BIT_FIFO_EN] |-> !fifo_pop_o;
    endproperty
    a_fifo_block: assert property (p_fifo_block) else $error("fifo access while disabled");

    property p_flag_hold;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (st.fill_flag && !data_read) |=> st.fill_flag;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without data read");

    property p_fifo_rst_start;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (wr_user && wbyte[BIT_FIFO_RST]) |=> fifo_reset_o;
    endproperty
    a_fifo_rst_start: assert property (p_fifo_rst_start) else $error("fifo reset not started");

    property p_accel_only;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (wr_path && wbyte[BIT_ACCEL_RST]) |=> accel_path_reset_o && !sensor_regs_clear_o;
    endproperty
    a_accel_only: assert property (p_accel_only) else $error("accel path reset wrong");

    property p_temp_only;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (wr_path && wbyte[BIT_TEMP_RST]) |=> temp_path_reset_o && !sensor_regs_clear_o;
    endproperty
    a_temp_only: assert property (p_temp_only) else $error("temp path reset wrong");

    property p_all_rst;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (wr_user && wbyte[BIT_ALL_RST]) |=> accel_path_reset_o && temp_path_reset_o && gyro_path_reset_o
                                            && sensor_regs_clear_o;
    endproperty
    a_all_rst: assert property (p_all_rst) else $error("all path reset incomplete");

    c_trigger: cover property (@(posedge clk_sys_i) disable iff (!nrst_i) $rose(st.fill_flag));
    c_clear:   cover property (@(posedge clk_sys_i) disable iff (!nrst_i) data_read && st.fill_flag);
    c_rearm:   cover property (@(posedge clk_sys_i) disable iff (!nrst_i) st.in_seq && !fifo_read_busy_i && cond);
    c_allrst:  cover property (@(posedge clk_sys_i) disable iff (!nrst_i) $rose(sensor_regs_clear_o));
    c_latch:   cover property (@(posedge clk_sys_i) disable iff (!nrst_i) st.latch_mode && $rose(st.irq_level));
endmodule

// *** dv/fwr_fifo_model.sv ***
// behavioural byte store standing in for the sensor fifo behind the control block
`timescale 1ns/1ps
module fwr_fifo_model (
    // clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        nrst_i,
    // fill side, driven by the bench
    input  wire logic        push_i,
    input  wire logic [7:0]  push_data_i,
    // control block side
    input  wire logic        fifo_pop_i,
    input  wire logic        fifo_reset_i,
    output logic [15:0]      fifo_count_o,
    output logic [7:0]       fifo_rdata_o
);
    logic [7:0] mem[$];
    logic [7:0] last = 8'h00;

    // outputs move by non-blocking assignment so the block sees them one edge late, as real logic would
    always @(posedge clk_sys_i or negedge nrst_i or posedge fifo_reset_i) begin
        if (!nrst_i || fifo_reset_i) begin
            mem.delete();
        end else begin
            if (fifo_pop_i && mem.size() > 0) begin
                last = mem.pop_front();
            end
            if (push_i) begin
                mem.push_back(push_data_i);
            end
        end
        fifo_count_o <= 16'(mem.size());
        // an empty store shows the inverse of the last byte so a stale value never matches
        fifo_rdata_o <= (mem.size() > 0) ? mem[0] : ~last;
    end
endmodule

// *** dv/fwr_ctrl_tb.sv ***
// self-checking bench for the fill-level and reset control block
`timescale 1ns/1ps
module fwr_ctrl_tb;
    import fwr_pkg::*;
    logic        clk_sys_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic        hsel_i = 1'b0;
    logic        hwrite_i = 1'b0;
    logic        hready_i;
    logic [31:0] haddr_i = '0;
    logic [1:0]  htrans_i = 2'b00;
    logic [2:0]  hsize_i = 3'b010;
    logic [31:0] hwdata_i = '0;
    logic [31:0] hrdata_o;
    logic        hreadyout_o, hresp_o, fifo_pop_o, fifo_enable_o, fifo_reset_o, irq_o;
    logic        accel_path_reset_o, temp_path_reset_o, gyro_path_reset_o, sensor_regs_clear_o;
    logic        motion_detect_enable_o, motion_compare_mode_o, output_limit_off_o, motion_axis_combine_o;
    logic [15:0] fifo_count_i;
    logic [7:0]  fifo_rdata_i;
    logic        fifo_read_busy_i = 1'b0;
    logic        push = 1'b0;
    logic [7:0]  push_data = '0;
    logic [31:0] rd_q, d;
    logic        rdy_q;
    logic [6:0]  mon;
    logic [7:0]  q[$];
    int          pc[7];
    int          mismatches = 0;
    int          tests_run = 0;
    int          cyc = 0;
    int          thr;

    assign hready_i = hreadyout_o;
    assign mon = {fifo_pop_o, accel_path_reset_o, temp_path_reset_o, gyro_path_reset_o,
                  sensor_regs_clear_o, fifo_reset_o, irq_o};

    fwr_ctrl fwr_ctrl_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
        .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .fifo_count_i(fifo_count_i),
        .fifo_rdata_i(fifo_rdata_i), .fifo_read_busy_i(fifo_read_busy_i), .fifo_pop_o(fifo_pop_o),
        .fifo_enable_o(fifo_enable_o), .fifo_reset_o(fifo_reset_o), .accel_path_reset_o(accel_path_reset_o),
        .temp_path_reset_o(temp_path_reset_o), .gyro_path_reset_o(gyro_path_reset_o),
        .sensor_regs_clear_o(sensor_regs_clear_o), .motion_detect_enable_o(motion_detect_enable_o),
        .motion_compare_mode_o(motion_compare_mode_o), .output_limit_off_o(output_limit_off_o),
        .motion_axis_combine_o(motion_axis_combine_o), .irq_o(irq_o));

    fwr_fifo_model fwr_fifo_model_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .push_i(push),
        .push_data_i(push_data), .fifo_pop_i(fifo_pop_o), .fifo_reset_i(fifo_reset_o),
        .fifo_count_o(fifo_count_i), .fifo_rdata_o(fifo_rdata_i));

    always #2 clk_sys_i = ~clk_sys_i;

    // bus answers and pulse widths are captured at the edge itself, before any update lands
    always @(posedge clk_sys_i) begin
        rd_q <= hrdata_o;
        rdy_q <= hreadyout_o;
        for (int i = 0; i < 7; i++) begin
            pc[i] += (mon[i] === 1'b1) ? 1 : 0;
        end
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            $display("[ERR] %0t run did not finish in time", $time);
            summarize();
        end
    end

    function automatic logic [31:0] masked(input logic [31:0] v, input logic [7:0] m);
        return {24'h0, v[7:0] & m};
    endfunction

    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) begin
            @(posedge clk_sys_i);
            #1;
        end
    endtask

    // one single transfer; the bench's own timeout ends a wait that never sees hready
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
        hsel_i <= 1'b1;
        haddr_i <= {22'h0, idx, 2'b00};
        htrans_i <= HTRANS_NONSEQ;
        hwrite_i <= wr;
        do begin
            settle(1);
        end while (rdy_q !== 1'b1);
        htrans_i <= 2'b00;
        hsel_i <= 1'b0;
        hwdata_i <= wd;
        do begin
            settle(1);
        end while (rdy_q !== 1'b1);
        rd = rd_q;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
        logic [31:0] dummy;
        bus(1'b1, idx, wd, dummy);
    endtask

    task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] got;
        bus(1'b0, idx, 32'h0, got);
        check(got, exp, $sformatf("read of index %h", idx));
    endtask

    task automatic fill(input int n);
        repeat (n) begin
            push <= 1'b1;
            push_data <= 8'($urandom());
            settle(1);
            q.push_back(push_data);
        end
        push <= 1'b0;
    endtask

    task automatic clr();
        for (int i = 0; i < 7; i++) begin
            pc[i] = 0;
        end
    endtask

    task automatic pulses(input logic [7:0] idx, input logic [31:0] wd, input int f, s, g, t, a);
        clr();
        wr(idx, wd);
        settle(FIFO_RST_CYCLES + 4);
        check(32'(pc[1]), 32'(f), "fifo reset width");
        check(32'(pc[2]), 32'(s), "sensor clear width");
        check(32'(pc[3]), 32'(g), "gyro reset width");
        check(32'(pc[4]), 32'(t), "temp reset width");
        check(32'(pc[5]), 32'(a), "accel reset width");
    endtask

    task automatic irqchk(input logic latch);
        if (latch) begin
            check({31'h0, irq_o}, 32'h1, "latched pin");
        end else begin
            check(32'(pc[0]), 32'h1, "pin pulse count");
        end
    endtask

    initial begin
        void'($urandom(47));
        repeat (8) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        settle(1);
        rdchk(IDX_THRESH_HIGH, {24'h0, RST_THRESH_HIGH});
        rdchk(IDX_THRESH_LOW, {24'h0, RST_THRESH_LOW});
        rdchk(IDX_MOTION_CTRL, {24'h0, RST_MOTION_CTRL});
        rdchk(IDX_USER_CTRL, {24'h0, RST_USER_CTRL});
        for (int i = 0; i < 8; i++) begin
            d = $urandom();
            wr(IDX_MOTION_CTRL, d);
            rdchk(IDX_MOTION_CTRL, masked(d, MASK_MOTION_CTRL));
            check({motion_detect_enable_o, motion_compare_mode_o, output_limit_off_o, motion_axis_combine_o},
                  {d[7], d[6], d[1], d[0]}, "motion settings");
            wr(IDX_THRESH_HIGH, d >> 8);
            rdchk(IDX_THRESH_HIGH, masked(d >> 8, MASK_THRESH_HIGH));
            wr(IDX_THRESH_LOW, d >> 16);
            rdchk(IDX_THRESH_LOW, masked(d >> 16, 8'hff));
            wr(IDX_USER_CTRL, d & 32'hfa);
            rdchk(IDX_USER_CTRL, masked(d, MASK_USER_CTRL));
            check({31'h0, fifo_enable_o}, {31'h0, d[6]}, "fifo enable");
            wr(8'h10 + 8'(i), d);
            rdchk(8'h10 + 8'(i), 32'h0);
            rdchk(IDX_PATH_RESET, 32'h0);
        end
        pulses(IDX_PATH_RESET, 32'h2, 0, 0, 0, 0, 1);
        pulses(IDX_PATH_RESET, 32'h1, 0, 0, 0, 1, 0);
        pulses(IDX_USER_CTRL, 32'h1, 0, 1, 1, 1, 1);
        fill(5);
        pulses(IDX_USER_CTRL, 32'h4, FIFO_RST_CYCLES, 0, 0, 0, 0);
        q.delete();
        rdchk(IDX_USER_CTRL, 32'h0);
        rdchk(IDX_FIFO_COUNT, 32'h0);
        // with the fifo disabled a data-port read must neither return data nor pop
        fill(2);
        clr();
        rdchk(IDX_FIFO_DATA, 32'h0);
        check(32'(pc[6]), 32'h0, "pop while disabled");
        rdchk(IDX_FIFO_COUNT, 32'h2);
        wr(IDX_CFG_1A, 32'h0);
        for (int k = 0; k < 4; k++) begin
            thr = (k == 0) ? 1 : (k == 1) ? 1023 : 256 + $urandom_range(744);
            // the flag from the last round stands until a data read; zero threshold keeps it from re-arming
            wr(IDX_THRESH_HIGH, 32'h0);
            wr(IDX_THRESH_LOW, 32'h0);
            wr(IDX_USER_CTRL, 32'h40);
            rdchk(IDX_FIFO_DATA, {24'h0, q.pop_front()});
            wr(IDX_USER_CTRL, 32'h44);
            settle(FIFO_RST_CYCLES + 2);
            q.delete();
            wr(IDX_INT_CFG, 32'(k % 2));
            wr(IDX_THRESH_HIGH, 32'(thr >> 8));
            wr(IDX_THRESH_LOW, 32'(thr));
            fill(thr - 1);
            settle(3);
            rdchk(IDX_IRQ_STATUS, 32'h0);
            clr();
            fill(3);
            settle(3);
            rdchk(IDX_IRQ_STATUS, 32'h1);
            irqchk(k % 2);
            rdchk(IDX_IRQ_STATUS, 32'h1);
            fifo_read_busy_i <= 1'b1;
            rdchk(IDX_FIFO_DATA, {24'h0, q.pop_front()});
            rdchk(IDX_IRQ_STATUS, 32'h0);
            check({31'h0, irq_o}, 32'h0, "pin after first read");
            clr();
            rdchk(IDX_FIFO_DATA, {24'h0, q.pop_front()});
            settle(3);
            rdchk(IDX_IRQ_STATUS, 32'h0);
            check({irq_o, 31'(pc[0])}, 32'h0, "pin during read");
            check(32'(pc[6]), 32'h1, "pop count");
            clr();
            fifo_read_busy_i <= 1'b0;
            settle(3);
            rdchk(IDX_IRQ_STATUS, 32'h1);
            irqchk(k % 2);
        end
        // a zero threshold keeps the flag down whatever the count
        wr(IDX_THRESH_HIGH, 32'h0);
        wr(IDX_THRESH_LOW, 32'h0);
        fifo_read_busy_i <= 1'b1;
        rdchk(IDX_FIFO_DATA, {24'h0, q.pop_front()});
        fifo_read_busy_i <= 1'b0;
        fill(2);
        settle(3);
        rdchk(IDX_IRQ_STATUS, 32'h0);
        summarize();
    end
endmodule
